// [design/drive_process_data_interface.sv]
`timescale 1ns/100ps
`default_nettype none
`include "pdi_cfg.svh"
module drive_process_data_interface (
	input  wire logic                   clk,
	input  wire logic                   rst,
	// output image from master, one byte per write
	input  wire logic                   img_wr,
	input  wire logic [5:0]             img_addr,
	input  wire logic [7:0]             img_data,
	input  wire logic                   img_commit,
	// status image read
	input  wire logic [5:0]             stat_addr,
	output logic      [7:0]             stat_data,
	// mode engine side
	input  wire pdi_pkg::motion_s       motion,
	input  wire logic [5:0]             phys_inputs,
	input  wire logic [5:0]             force_value,
	input  wire logic [5:0]             force_enable,
	input  wire logic                   homing_done,
	input  wire logic                   standstill_in,
	input  wire logic                   fault_event,
	input  wire logic                   warn_in,
	input  wire logic [2:0]             mode_info,
	input  wire logic [31:0]            position_in,
	input  wire logic [31:0]            velocity_in,
	input  wire logic [7:0]             pc_resp_subaddr,
	input  wire logic [7:0]             pc_resp_request,
	input  wire logic [15:0]            pc_resp_index,
	input  wire logic [31:0]            pc_resp_value,
	// drive control outputs
	output logic                        power_stage_on,
	output pdi_pkg::mode_req_s          mode_start,
	output logic                        mode_start_valid,
	output logic [31:0]                 ramp_up_rate,
	output logic [31:0]                 ramp_down_rate,
	output logic [15:0]                 mode_fault_code,
	output logic                        pause_active
);
	// ==========================================
	// output image capture
	logic [7:0] img [0:`OUTPUT_BYTES-1];
	logic [7:0] prev_state;
	logic       prev_toggle;
	logic [5:0] in_s1, in_s2;
	always_ff @(posedge clk) begin
		if (img_wr && img_addr < 6'(`OUTPUT_BYTES))
			img[img_addr] <= img_data;
	end
	always_ff @(posedge clk) begin
		in_s1 <= phys_inputs;
		in_s2 <= in_s1;
	end
	// ==========================================
	// state command decode
	pdi_pkg::state_cmd_s cmd, rise;
	pdi_pkg::drive_state_e state, next_state;
	assign cmd  = img[`OUT_STATE_BYTE];
	assign rise = cmd & ~prev_state;
	always_comb begin
		next_state = state;
		if (cmd == 8'h00 || rise.power_off) begin
			if (state == pdi_pkg::st_enabled || state == pdi_pkg::st_switch_on)
				next_state = pdi_pkg::st_ready;
		end else if (rise.rapid_stop) begin
			if (state == pdi_pkg::st_enabled)
				next_state = pdi_pkg::st_quick_stop; // ignored elsewhere
		end else if (rise.err_clear) begin
			if (state == pdi_pkg::st_fault)
				next_state = pdi_pkg::st_ready;
		end else if (rise.power_on) begin
			if (state == pdi_pkg::st_ready || state == pdi_pkg::st_quick_stop)
				next_state = pdi_pkg::st_enabled;
		end
		if (fault_event)
			next_state = pdi_pkg::st_fault;
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			state      <= pdi_pkg::st_ready;
			prev_state <= 8'h00;
		end else if (img_commit) begin
			state      <= next_state;
			prev_state <= cmd;
		end else if (fault_event) begin
			state <= pdi_pkg::st_fault;
		end
	end
	always_ff @(posedge clk) begin
		if (rst)
			pause_active <= 1'b0;
		else if (fault_event)
			pause_active <= 1'b0;
		else if (img_commit && next_state != pdi_pkg::st_enabled)
			pause_active <= 1'b0; // leaving enabled drops pause in the same commit
		else if (img_commit && rise.pause)
			pause_active <= 1'b1;
		else if (img_commit && (rise.release_p || rise.resume))
			pause_active <= 1'b0;
	end
	always_ff @(posedge clk) begin
		if (rst)
			power_stage_on <= 1'b0;
		else
			power_stage_on <= (state == pdi_pkg::st_enabled);
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			ramp_up_rate   <= 32'h0000_0000;
			ramp_down_rate <= 32'h0000_0000;
		end else if (img_commit) begin
			ramp_up_rate   <= {img[19], img[18], img[17], img[16]};
			ramp_down_rate <= {img[23], img[22], img[21], img[20]};
		end
	end
	// ==========================================
	// mode request handshake
	logic [7:0] mcmd;
	logic       mode_ok;
	logic [3:0] active_mode;
	logic       reject, home_ok, stat_toggle;
	assign mcmd = img[`OUT_MODE_BYTE];
	always_comb begin
		case (mcmd[3:0])
			`MODE_JOG, `MODE_HOMING, `MODE_PROF_POS,
			`MODE_PROF_VEL, `MODE_SPEED: mode_ok = 1'b1;
			default: mode_ok = 1'b0;
		endcase
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			prev_toggle      <= 1'b0;
			stat_toggle      <= 1'b0;
			reject           <= 1'b0;
			active_mode      <= 4'h0;
			mode_fault_code  <= 16'h0000;
			mode_start_valid <= 1'b0;
			mode_start       <= '0;
		end else begin
			mode_start_valid <= 1'b0;
			if (img_commit) begin
				prev_toggle <= mcmd[7];
				if (mcmd == 8'h00) begin
					// skipped silently
				end else if (mcmd[7] != prev_toggle) begin
					stat_toggle <= mcmd[7];
					if (!mode_ok) begin
						reject          <= 1'b1;
						mode_fault_code <= `FAULT_BAD_MODE;
					end else if (state != pdi_pkg::st_enabled) begin
						reject          <= 1'b1;
						mode_fault_code <= `FAULT_NOT_ENABLED;
					end else if (!standstill_in) begin
						reject          <= 1'b1;
						mode_fault_code <= `FAULT_NOT_STILL;
					end else begin
						reject           <= 1'b0;
						active_mode      <= mcmd[3:0];
						mode_start_valid <= 1'b1;
						mode_start       <= {mcmd[3:0], mcmd[6:4], mcmd[7],
							img[11], img[10], img[9], img[8], img[13], img[12]};
					end
				end
			end
		end
	end
	always_ff @(posedge clk) begin
		if (rst)
			home_ok <= 1'b0;
		else if (homing_done)
			home_ok <= 1'b1; // set wins over a same-cycle restart
		else if (mode_start_valid && mode_start.mode == `MODE_HOMING)
			home_ok <= 1'b0;
	end
	// ==========================================
	// status image
	logic [7:0]  inputs_byte;
	logic [15:0] motion_word, state_word;
	logic [7:0]  mode_byte;
	assign inputs_byte = {2'b00, (force_enable & force_value) | (~force_enable & in_s2)};
	assign motion_word = {1'b0, motion.cruise, motion.speedup, motion.braking,
		motion.tgt_zero, 1'b0, motion.in_window, motion.moving_rev,
		motion.moving_fwd, motion.standstill, 6'h00};
	assign mode_byte = {stat_toggle, reject, home_ok, 1'b0, active_mode};
	assign state_word = {mode_info, 4'h0, pause_active,
		warn_in, state == pdi_pkg::st_fault, 2'b00, state};
	logic [7:0] next_stat;
	always_comb begin
		case (stat_addr)
			6'h00: next_stat = pc_resp_subaddr;
			6'h01: next_stat = pc_resp_request;
			6'h02: next_stat = pc_resp_index[7:0];
			6'h03: next_stat = pc_resp_index[15:8];
			6'h04: next_stat = pc_resp_value[7:0];
			6'h05: next_stat = pc_resp_value[15:8];
			6'h06: next_stat = pc_resp_value[23:16];
			6'h07: next_stat = pc_resp_value[31:24];
			6'h0E: next_stat = motion_word[7:0];
			6'h0F: next_stat = motion_word[15:8];
			6'h10: next_stat = inputs_byte;
			6'h11: next_stat = mode_byte;
			6'h12: next_stat = state_word[7:0];
			6'h13: next_stat = state_word[15:8];
			6'h14: next_stat = position_in[7:0];
			6'h15: next_stat = position_in[15:8];
			6'h16: next_stat = position_in[23:16];
			6'h17: next_stat = position_in[31:24];
			6'h18: next_stat = velocity_in[7:0];
			6'h19: next_stat = velocity_in[15:8];
			6'h1A: next_stat = velocity_in[23:16];
			6'h1B: next_stat = velocity_in[31:24];
			default: next_stat = 8'h00; // special and reserved
		endcase
	end
	always_ff @(posedge clk) begin
		if (rst)
			stat_data <= 8'h00;
		else
			stat_data <= next_stat;
	end
	// ==========================================
	// checks
	chk_off_wins: assert property (@(posedge clk) disable iff (rst)
		img_commit && rise.power_off && state == pdi_pkg::st_enabled && !fault_event
		|=> state == pdi_pkg::st_ready) else $error("power off lost");
	chk_zero_disables: assert property (@(posedge clk) disable iff (rst)
		img_commit && cmd == 8'h00 && !fault_event |=> state != pdi_pkg::st_enabled)
		else $error("zero byte kept stage on");
	chk_stop_beats_clear: assert property (@(posedge clk) disable iff (rst)
		img_commit && rise.rapid_stop && rise.err_clear && !rise.power_off && cmd != 8'h00
		&& state == pdi_pkg::st_enabled && !fault_event
		|=> state == pdi_pkg::st_quick_stop) else $error("rapid stop lost");
	chk_pause_wins: assert property (@(posedge clk) disable iff (rst)
		img_commit && rise.pause && next_state == pdi_pkg::st_enabled |=> pause_active)
		else $error("pause lost");
	chk_toggle_echo: assert property (@(posedge clk) disable iff (rst)
		img_commit && mcmd != 8'h00 && mcmd[7] != prev_toggle
		|=> stat_toggle == $past(mcmd[7])) else $error("toggle not echoed");
	chk_no_toggle_idle: assert property (@(posedge clk) disable iff (rst)
		img_commit && mcmd[7] == prev_toggle |=> !mode_start_valid)
		else $error("mode taken without toggle");
	chk_bad_mode_rej: assert property (@(posedge clk) disable iff (rst)
		img_commit && mcmd != 8'h00 && mcmd[7] != prev_toggle && !mode_ok
		|=> reject && mode_fault_code == `FAULT_BAD_MODE) else $error("no reject");
	chk_zero_mode_skip: assert property (@(posedge clk) disable iff (rst)
		img_commit && mcmd == 8'h00 |=> $stable(reject) && !mode_start_valid)
		else $error("zero mode acted");
	chk_stage_follows: assert property (@(posedge clk) disable iff (rst)
		state == pdi_pkg::st_enabled |=> power_stage_on) else $error("stage lag");

	chk_stage_drops: assert property (@(posedge clk) disable iff (rst)
		state != pdi_pkg::st_enabled |=> !power_stage_on) else $error("stage stuck on");

	chk_state_hold: assert property (@(posedge clk) disable iff (rst)
		!img_commit && !fault_event |=> $stable(state)) else $error("state moved idle");

	chk_level_only: assert property (@(posedge clk) disable iff (rst)
		img_commit && rise == 8'h00 && cmd != 8'h00 && !fault_event
		|=> $stable(state)) else $error("level acted");

	chk_on_ready: assert property (@(posedge clk) disable iff (rst)
		img_commit && rise.power_on && !rise.power_off && !rise.rapid_stop
		&& !rise.err_clear && state == pdi_pkg::st_ready && !fault_event
		|=> state == pdi_pkg::st_enabled) else $error("power on lost");

	chk_stop_ignored: assert property (@(posedge clk) disable iff (rst)
		img_commit && rise.rapid_stop && !rise.power_off && cmd != 8'h00
		&& state == pdi_pkg::st_ready && !fault_event
		|=> state == pdi_pkg::st_ready) else $error("stop not ignored");

	chk_clear_fault: assert property (@(posedge clk) disable iff (rst)
		img_commit && rise.err_clear && !rise.rapid_stop && !rise.power_off
		&& cmd != 8'h00 && state == pdi_pkg::st_fault && !fault_event
		|=> state == pdi_pkg::st_ready) else $error("clear lost");

	chk_fault_entry: assert property (@(posedge clk) disable iff (rst)
		fault_event |=> state == pdi_pkg::st_fault) else $error("fault missed");

	chk_pause_drop: assert property (@(posedge clk) disable iff (rst)
		img_commit && next_state != pdi_pkg::st_enabled |=> !pause_active)
		else $error("pause kept");

	chk_pause_release: assert property (@(posedge clk) disable iff (rst)
		img_commit && rise.release_p && !rise.pause && next_state == pdi_pkg::st_enabled
		&& !fault_event |=> !pause_active) else $error("release lost");

	chk_ramp_load: assert property (@(posedge clk) disable iff (rst)
		img_commit |=> ramp_down_rate == $past({img[23], img[22], img[21], img[20]}))
		else $error("ramp not loaded");

	chk_home_set: assert property (@(posedge clk) disable iff (rst)
		homing_done |=> home_ok) else $error("homing flag lost");

	// ==========================================
	// mode handshake checks
	chk_rej_idle: assert property (@(posedge clk) disable iff (rst)
		img_commit && mcmd != 8'h00 && mcmd[7] != prev_toggle && mode_ok
		&& state != pdi_pkg::st_enabled
		|=> reject && mode_fault_code == `FAULT_NOT_ENABLED) else $error("idle mode kept");

	chk_rej_moving: assert property (@(posedge clk) disable iff (rst)
		img_commit && mcmd != 8'h00 && mcmd[7] != prev_toggle && mode_ok
		&& state == pdi_pkg::st_enabled && !standstill_in
		|=> reject && mode_fault_code == `FAULT_NOT_STILL) else $error("moving mode kept");

	chk_mode_accept: assert property (@(posedge clk) disable iff (rst)
		img_commit && mcmd != 8'h00 && mcmd[7] != prev_toggle && mode_ok
		&& state == pdi_pkg::st_enabled && standstill_in
		|=> mode_start_valid && !reject && mode_start.mode == $past(mcmd[3:0]))
		else $error("mode not started");

	chk_mode_shown: assert property (@(posedge clk) disable iff (rst)
		mode_start_valid |-> active_mode == mode_start.mode) else $error("mode not shown");

	chk_mode_hold: assert property (@(posedge clk) disable iff (rst)
		!(img_commit && mcmd != 8'h00 && mcmd[7] != prev_toggle)
		|=> $stable(stat_toggle) && $stable(mode_fault_code) && !mode_start_valid)
		else $error("mode moved idle");

	// ==========================================
	// status read checks
	// data lags the address by one edge, so each check looks one cycle on
	chk_read_state: assert property (@(posedge clk) disable iff (rst)
		stat_addr == `OFS_STATE_WORD |=> stat_data[3:0] == $past(state)
		&& stat_data[6] == ($past(state) == pdi_pkg::st_fault)) else $error("bad state read");

	chk_read_mode: assert property (@(posedge clk) disable iff (rst)
		stat_addr == `OFS_MODE_STAT |=> stat_data == {$past(stat_toggle), $past(reject),
		$past(home_ok), 1'b0, $past(active_mode)}) else $error("bad mode read");

	chk_read_inputs: assert property (@(posedge clk) disable iff (rst)
		stat_addr == `OFS_INPUTS |=> stat_data[7:6] == 2'b00) else $error("bad input read");

	chk_forced_in: assert property (@(posedge clk) disable iff (rst)
		stat_addr == `OFS_INPUTS && force_enable == 6'h3F
		|=> stat_data[5:0] == $past(force_value)) else $error("force ignored");

	chk_read_special: assert property (@(posedge clk) disable iff (rst)
		stat_addr == `OFS_SPECIAL || stat_addr == 6'h0D |=> stat_data == 8'h00)
		else $error("special not zero");

	chk_read_spare: assert property (@(posedge clk) disable iff (rst)
		stat_addr >= 6'h1C |=> stat_data == 8'h00) else $error("spare not zero");

	chk_read_motion: assert property (@(posedge clk) disable iff (rst)
		stat_addr == `OFS_MOTION |=> stat_data[5:0] == 6'h00) else $error("motion low bits");

	chk_read_pos: assert property (@(posedge clk) disable iff (rst)
		stat_addr == `OFS_POSITION |=> stat_data == $past(position_in[7:0]))
		else $error("bad position read");

	chk_read_vel: assert property (@(posedge clk) disable iff (rst)
		stat_addr == `OFS_VELOCITY |=> stat_data == $past(velocity_in[7:0]))
		else $error("bad velocity read");

	// ==========================================
	// coverage of the main scenarios
	cov_enable: cover property (@(posedge clk) state == pdi_pkg::st_enabled);
	cov_mode_start: cover property (@(posedge clk) mode_start_valid);
	cov_reject: cover property (@(posedge clk) reject);
	cov_pause: cover property (@(posedge clk) pause_active);
endmodule
`default_nettype wire

// [pkg/pdi_cfg.svh]
`ifndef PDI_CFG_SVH
`define PDI_CFG_SVH
`define OFS_PC_SUBADDR   6'h00
`define OFS_PC_REQUEST   6'h01
`define OFS_PC_INDEX     6'h02
`define OFS_PC_VALUE     6'h04
`define OFS_SPECIAL      6'h0C
`define OFS_MOTION       6'h0E
`define OFS_INPUTS       6'h10
`define OFS_MODE_STAT    6'h11
`define OFS_STATE_WORD   6'h12
`define OFS_POSITION     6'h14
`define OFS_VELOCITY     6'h18
`define OUT_MODE_BYTE    6'h0E
`define OUT_STATE_BYTE   6'h0F
`define STATUS_BYTES     44
`define OUTPUT_BYTES     40
`define MODE_JOG         4'h1
`define MODE_HOMING      4'h2
`define MODE_PROF_POS    4'h3
`define MODE_PROF_VEL    4'h4
`define MODE_SPEED       4'h7
`define FAULT_BAD_MODE   16'h0001
`define FAULT_NOT_ENABLED 16'h0002
`define FAULT_NOT_STILL  16'h0003
`define ST_READY         4'h4
`define ST_SWITCHED_ON   4'h5
`define ST_ENABLED       4'h6
`define ST_QUICK_STOP    4'h7
`define ST_FAULT         4'h9
`endif

// [pkg/pdi_pkg.sv]
package pdi_pkg;
	typedef enum logic [3:0] {
		st_ready      = 4'h4,
		st_switch_on  = 4'h5,
		st_enabled    = 4'h6,
		st_quick_stop = 4'h7,
		st_fault      = 4'h9
	} drive_state_e;
	typedef struct packed {
		logic resume;
		logic release_p;
		logic pause;
		logic reserved;
		logic err_clear;
		logic rapid_stop;
		logic power_on;
		logic power_off;
	} state_cmd_s;
	typedef struct packed {
		logic standstill;
		logic moving_fwd;
		logic moving_rev;
		logic in_window;
		logic tgt_zero;
		logic braking;
		logic speedup;
		logic cruise;
	} motion_s;
	typedef struct packed {
		logic [3:0] mode;
		logic [2:0] action;
		logic       toggle;
		logic [31:0] ref32;
		logic [15:0] ref16;
	} mode_req_s;
endpackage

// [testbench/drive_process_data_interface_test.sv]
`timescale 1ns/100ps
`default_nettype none
module drive_process_data_interface_test;
	logic clk = 1'b0, rst = 1'b1, rd_v = 1'b0, pend = 1'b0;
	logic homing_done = 1'b0, fault_event = 1'b0, standstill_in = 1'b1;
	logic img_wr, img_commit, warn_in, mode_start_valid, power_stage_on, pause_active;
	logic [5:0] img_addr, phys_inputs, force_value, force_enable;
	logic [5:0] stat_addr = 6'h00;
	logic [7:0] img_data, stat_data, pc_resp_subaddr, pc_resp_request, m;
	logic [7:0] codes [5] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h17};
	logic [2:0] mode_info;
	logic [15:0] pc_resp_index, mode_fault_code;
	logic [31:0] position_in, velocity_in, pc_resp_value, ramp_up_rate, ramp_down_rate;
	logic [63:0] r, pc, pv;
	logic [7:0] expq [$];
	pdi_pkg::motion_s motion;
	pdi_pkg::mode_req_s mode_start;
	integer seed = 32'h9f5b;
	int fail_count = 0, n_compared = 0, n_valid = 0;
	always #2 clk = ~clk;
	drive_process_data_interface u_dut (.clk, .rst, .img_wr, .img_addr, .img_data,
		.img_commit, .stat_addr, .stat_data, .motion, .phys_inputs, .force_value,
		.force_enable, .homing_done, .standstill_in, .fault_event, .warn_in, .mode_info,
		.position_in, .velocity_in, .pc_resp_subaddr, .pc_resp_request, .pc_resp_index,
		.pc_resp_value, .power_stage_on, .mode_start, .mode_start_valid, .ramp_up_rate,
		.ramp_down_rate, .mode_fault_code, .pause_active);
	plc_master_model u_plc (.clk, .img_wr, .img_addr, .img_data, .img_commit);
	// ==========================================
	// checking
	task chk(input logic [31:0] s, input logic [31:0] e);
		n_compared++;
		if (s !== e) begin
			fail_count++;
			$display("BAD %0t seen %h want %h", $time, s, e);
		end
	endtask
	task rd(input logic [5:0] a, input logic [7:0] e);
		@(negedge clk);
		stat_addr = a;
		rd_v = 1'b1;
		expq.push_back(e);
		@(negedge clk);
		rd_v = 1'b0;
	endtask
	task st(input logic [3:0] s);
		rd(6'h12, {warn_in, s == 4'h9, 2'b00, s});
	endtask
	task test_done;
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// read data is registered, so it is judged one edge after the address
	always @(posedge clk) begin
		pend <= rd_v;
		if (mode_start_valid === 1'b1) n_valid++;
	end
	always @(negedge clk) begin
		if (pend) chk(stat_data, expq.pop_front());
	end
	initial begin
		#100000;
		fail_count++;
		test_done;
	end
	// ==========================================
	// stimulus
	initial begin
		{pc_resp_value, pc_resp_index, pc_resp_request, pc_resp_subaddr} = {$random(seed), $random(seed)};
		{position_in, velocity_in} = {$random(seed), $random(seed)};
		{motion, phys_inputs, force_value, force_enable, mode_info, warn_in} = 30'($random(seed));
		r = {$random(seed), $random(seed)};
		repeat (12) @(negedge clk);
		rst = 1'b0;
		for (int i = 0; i < 8; i++) u_plc.put(6'(16 + i), r[8*i +: 8]);
		u_plc.put(6'h0E, 8'h00);
		u_plc.send(6'h0F, 8'h04);
		st(4'h4);
		chk(ramp_up_rate, r[31:0]);
		chk(ramp_down_rate, r[63:32]);
		u_plc.send(6'h0F, 8'h00);
		u_plc.send(6'h0F, 8'h03);
		st(4'h4);
		chk(power_stage_on, 1'b0);
		u_plc.send(6'h0F, 8'h00);
		u_plc.send(6'h0F, 8'h02);
		st(4'h6);
		chk(power_stage_on, 1'b1);
		u_plc.send(6'h0F, 8'h00);
		chk(power_stage_on, 1'b0);
		u_plc.send(6'h0F, 8'h02);
		$display("state command test done");
		for (int i = 0; i < 6; i++) u_plc.put(6'(8 + i), r[8*i +: 8]);
		u_plc.send(6'h0E, 8'h84);
		chk(n_valid, 1);
		chk(mode_start.ref32, r[31:0]);
		chk(mode_start.ref16, r[47:32]);
		chk(mode_start.action, 3'h0);
		chk(mode_start.mode, 4'h4);
		rd(6'h11, 8'h84);
		u_plc.send(6'h0E, 8'h05);
		rd(6'h11, 8'h44);
		chk(mode_fault_code, 16'h0001);
		u_plc.send(6'h0E, 8'h07);
		chk(n_valid, 1);
		for (int i = 0; i < 5; i++) begin
			u_plc.send(6'h0E, codes[i] | {~i[0], 7'h00});
			chk(n_valid, 2 + i);
			rd(6'h11, codes[i][3:0] | {~i[0], 7'h00});
		end
		@(negedge clk);
		homing_done = 1'b1;
		@(negedge clk);
		homing_done = 1'b0;
		rd(6'h11, 8'hA7);
		$display("mode test done");
		u_plc.send(6'h0F, 8'h72);
		chk(pause_active, 1'b1);
		rd(6'h13, {mode_info, 4'h0, 1'b1});
		u_plc.send(6'h0F, 8'h0C);
		st(4'h7);
		chk(pause_active, 1'b0);
		@(negedge clk);
		fault_event = 1'b1;
		@(negedge clk);
		fault_event = 1'b0;
		st(4'h9);
		u_plc.send(6'h0F, 8'h00);
		u_plc.send(6'h0F, 8'h08);
		st(4'h4);
		u_plc.send(6'h0E, 8'h04);
		rd(6'h11, 8'h67);
		chk(mode_fault_code, 16'h0002);
		u_plc.send(6'h0F, 8'h00);
		u_plc.send(6'h0F, 8'h02);
		standstill_in = 1'b0;
		u_plc.send(6'h0E, 8'h83);
		standstill_in = 1'b1;
		rd(6'h11, 8'hE7);
		chk(mode_fault_code, 16'h0003);
		chk(n_valid, 6);
		$display("precedence and fault test done");
		pc = {pc_resp_value, pc_resp_index, pc_resp_request, pc_resp_subaddr};
		pv = {velocity_in, position_in};
		for (int i = 0; i < 8; i++) begin
			rd(6'(i), pc[8*i +: 8]);
			rd(6'(20 + i), pv[8*i +: 8]);
		end
		rd(6'h0C, 8'h00);
		rd(6'h0D, 8'h00);
		m = motion;
		rd(6'h0E, {m[6], m[7], 6'h00});
		rd(6'h0F, {1'b0, m[0], m[1], m[2], m[3], 1'b0, m[4], m[5]});
		for (int k = 0; k < 2; k++) begin
			phys_inputs = ~phys_inputs;
			repeat (4) @(negedge clk);
			rd(6'h10, {2'b00, (phys_inputs & ~force_enable) | (force_value & force_enable)});
		end
		$display("status image test done");
		repeat (2) @(negedge clk);
		test_done;
	end
endmodule
`default_nettype wire

// [testbench/plc_master_model.sv]
`timescale 1ns/100ps
`default_nettype none
module plc_master_model (
	// clock
	input  wire logic clk,
	// output image writes
	output logic      img_wr,
	output logic [5:0] img_addr,
	output logic [7:0] img_data,
	output logic      img_commit
);
	initial begin
		img_wr = 1'b0;
		img_addr = 6'h3F;
		img_data = 8'h00;
		img_commit = 1'b0;
	end
	// a released data bus shows the inverse, so a stale byte never looks valid
	task put(input logic [5:0] a, input logic [7:0] d);
		@(negedge clk);
		img_wr = 1'b1;
		img_addr = a;
		img_data = d;
		@(negedge clk);
		img_wr = 1'b0;
		img_data = ~d;
	endtask
	task send(input logic [5:0] a, input logic [7:0] d);
		put(a, d);
		@(negedge clk);
		img_commit = 1'b1;
		@(negedge clk);
		img_commit = 1'b0;
		repeat (2) @(negedge clk);
	endtask
endmodule
`default_nettype wire
